// ===== core/pcdc_pkg.sv
/*
  pcdc_pkg: constants, register layout and divide tables for the
  clock divider control block.
  assumes: 32-bit APB slave, one system clock acting as the vco in pll mode.
*/
package pcdc_pkg;

  // apb geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register byte offsets
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] STAT_OFS = 8'h04;

  // control register layout, bit 0 first from the right
  typedef struct packed {
    logic [1:0] fb_sel;   // feedback_divide_select
    logic bank_c_sel;     // bank_c_divide_select
    logic bank_b_sel;     // bank_b_divide_select
    logic bank_a_sel;     // bank_a_divide_select
    logic rst_oe_n;       // reset_output_enable_n
    logic clk_run;        // clock-stop control, low stops banks
    logic pll_enable;     // low bypasses the pll
    logic vco_prescale_select;        // vco_prescale_select
    logic ref_sel;        // ref_select
  } pcdc_cfg_s;

  localparam int CTRL_W = $bits(pcdc_cfg_s);
  localparam pcdc_cfg_s CTRL_RST = 10'h01c;

  // status register layout
  typedef struct packed {
    logic dev_rst;        // device held in reset
    logic feedback_clk_in;          // sampled feedback_clk_in
    logic ref_level;      // sampled selected reference
    logic fb_q;           // feedback divider phase
    logic c_q;            // bank c divider phase
    logic b_q;            // bank b divider phase
    logic a_q;            // bank a divider phase
    logic loop_closed;    // pll loop closed
  } pcdc_stat_s;

  localparam int STAT_W = $bits(pcdc_stat_s);

  // divider indices
  localparam int DIV_A = 0;
  localparam int DIV_B = 1;
  localparam int DIV_C = 2;
  localparam int DIV_FB = 3;
  localparam int NDIV = 4;

  // half periods in vco ticks; index {vco_prescale_select, select}
  localparam int HALF_AB [4] = '{2, 4, 4, 8};
  localparam int HALF_C [4] = '{4, 6, 8, 12};
  localparam int HALF_FB [8] = '{4, 8, 6, 12, 8, 16, 12, 24};

endpackage : pcdc_pkg

// ===== core/pcdc_core.sv
/*
  pcdc_core: configuration and output divider logic of a fifteen-output
  clock generator, with an APB register slave.
  assumes: clk_sys_i stands in for the vco in pll mode; reference and
  feedback pins arrive synchronous to clk_sys_i; pads resolve the
  output enables; the board loops feedback_clk_out_o to feedback_clk_in_i.
*/
// Functional notes
// - ref_select low routes primary reference, high routes alternate; default low.
// - vco_prescale_select low scales vco by two, high by four; default low.
// - pll enable low bypasses pll, reference clocks the dividers; default high.
// - clock-stop low forces banks a, b, c static low; default running.
// - feedback output keeps running whatever the clock-stop level.
// - first bank pulse after clock-stop release may be short.
// - reset/output-enable low tri-states outputs and holds device reset; default high.
// - during reset the loop is open and the vco sits at lowest rate.
// - internal power-on reset needs no external action.
// - banks a and b divide by 4, 8, 8, 16 for codes 00..11.
// - bank c divides by 8, 12, 16, 24 for codes 00..11.
// - feedback divides 8, 16, 12, 24 or 16, 32, 24, 48 by vco select.
module pcdc_core
  import pcdc_pkg::*;
#(
  parameter int CNT_W = 5
) (
  // system
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_DW-1:0] pwdata_i,
  output logic [APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // reference and feedback pins
  input wire logic ref_clk_primary_i,
  input wire logic ref_clk_alternate_i,
  input wire logic feedback_clk_in_i,
  // bank outputs with enables
  output logic [4:0] bank_a_clk_out_o,
  output logic [4:0] bank_a_clk_oe_o,
  output logic [4:0] bank_b_clk_out_o,
  output logic [4:0] bank_b_clk_oe_o,
  output logic [3:0] bank_c_clk_out_o,
  output logic [3:0] bank_c_clk_oe_o,
  // feedback output with enable
  output logic feedback_clk_out_o,
  output logic feedback_clk_oe_o
);

  pcdc_cfg_s cfg_r;
  pcdc_stat_s stat;
  logic [APB_DW-1:0] prdata_r;
  logic access;
  logic mapped;
  logic dev_rst;
  logic sel_ref;
  logic ref_d_r;
  logic ref_q_r;
  logic feedback_clk_in_r;
  logic vco_tick;
  logic [NDIV-1:0] div_q_r;
  logic [CNT_W-1:0] cnt_r [NDIV];
  logic [CNT_W-1:0] half [NDIV];
  logic [4:0] a_r;
  logic [4:0] b_r;
  logic [3:0] c_r;
  logic fb_r;
  logic oe_r;

  // apb decode; zero wait states, unmapped answers slverr
  assign access = psel_i & penable_i;
  assign mapped = (paddr_i == CTRL_OFS) || (paddr_i == STAT_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign prdata_o = prdata_r;

  // control register; only rstn_i clears it, so software reset can be undone
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r <= CTRL_RST;
    end else if (access && pwrite_i && paddr_i == CTRL_OFS) begin
      cfg_r <= pwdata_i[CTRL_W-1:0];
    end
  end

  // read data latched in the setup phase so it comes from a flop
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_r <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (paddr_i == CTRL_OFS) begin
        prdata_r <= {{(APB_DW-CTRL_W){1'b0}}, cfg_r};
      end else if (paddr_i == STAT_OFS) begin
        prdata_r <= {{(APB_DW-STAT_W){1'b0}}, stat};
      end else begin
        prdata_r <= '0;
      end
    end
  end

  // device reset from the reset/output-enable control
  assign dev_rst = ~cfg_r.rst_oe_n;

  // status view of the block's own state
  always_comb begin
    stat.dev_rst = dev_rst;
    stat.feedback_clk_in = feedback_clk_in_r;
    stat.ref_level = ref_d_r;
    stat.fb_q = div_q_r[DIV_FB];
    stat.c_q = div_q_r[DIV_C];
    stat.b_q = div_q_r[DIV_B];
    stat.a_q = div_q_r[DIV_A];
    stat.loop_closed = cfg_r.pll_enable & ~dev_rst;
  end

  // reference selection and edge detect for bypass mode
  assign sel_ref = cfg_r.ref_sel ? ref_clk_alternate_i : ref_clk_primary_i;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_d_r <= 1'b0;
      ref_q_r <= 1'b0;
      feedback_clk_in_r <= 1'b0;
    end else begin
      ref_d_r <= sel_ref;
      ref_q_r <= ref_d_r;
      feedback_clk_in_r <= feedback_clk_in_i;
    end
  end

  // vco ticks every cycle in pll mode; bypass ticks on reference rises.
  // in reset no tick at all: the vco rests at its lowest rate
  always_comb begin
    if (dev_rst) begin
      vco_tick = 1'b0;
    end else if (cfg_r.pll_enable) begin
      vco_tick = 1'b1;
    end else begin
      vco_tick = ref_d_r & ~ref_q_r;
    end
  end

  // half periods from the divide tables; vco select picks the row
  always_comb begin
    half[DIV_A] = CNT_W'(HALF_AB[{cfg_r.vco_prescale_select, cfg_r.bank_a_sel}]);
    half[DIV_B] = CNT_W'(HALF_AB[{cfg_r.vco_prescale_select, cfg_r.bank_b_sel}]);
    half[DIV_C] = CNT_W'(HALF_C[{cfg_r.vco_prescale_select, cfg_r.bank_c_sel}]);
    half[DIV_FB] = CNT_W'(HALF_FB[{cfg_r.vco_prescale_select, cfg_r.fb_sel}]);
  end

  // one divider per bank plus feedback; all share reset for alignment
  for (genvar i = 0; i < NDIV; i++) begin : g_div
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cnt_r[i] <= '0;
        div_q_r[i] <= 1'b0;
      end else if (dev_rst) begin
        cnt_r[i] <= '0;
        div_q_r[i] <= 1'b0;
      end else if (vco_tick) begin
        // a select change mid-count may stretch or cut one half period
        if (cnt_r[i] >= half[i] - CNT_W'(1)) begin
          cnt_r[i] <= '0;
          div_q_r[i] <= ~div_q_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + CNT_W'(1);
        end
      end
    end

    // a shorter half period chosen mid-count ends the running count at once
    property p_div_period;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ($changed(div_q_r[i]) && !$past(dev_rst))
        |-> ($past(cnt_r[i]) >= $past(half[i]) - CNT_W'(1));
    endproperty
    a_div_period: assert property (p_div_period)
      else $error("divider toggled at wrong count");

    // no toggle before the count reaches the end of its half period
    property p_div_early;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (vco_tick && !dev_rst && (cnt_r[i] < half[i] - CNT_W'(1))) |=> $stable(div_q_r[i]);
    endproperty
    a_div_early: assert property (p_div_early)
      else $error("divider toggled before its count ended");

    property p_div_hold;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (!vco_tick && !dev_rst) |=> $stable(cnt_r[i]) && $stable(div_q_r[i]);
    endproperty
    a_div_hold: assert property (p_div_hold)
      else $error("divider moved without a vco tick");
  end

  // output flops; clock-stop gates banks only, feedback runs free.
  // the divider keeps counting while stopped, so the first pulse after
  // release may be short
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_r <= '0;
      b_r <= '0;
      c_r <= '0;
      fb_r <= 1'b0;
    end else begin
      a_r <= {5{div_q_r[DIV_A] & cfg_r.clk_run}};
      b_r <= {5{div_q_r[DIV_B] & cfg_r.clk_run}};
      c_r <= {4{div_q_r[DIV_C] & cfg_r.clk_run}};
      fb_r <= div_q_r[DIV_FB];
    end
  end

  // output enables; pads float while reset/output-enable is low
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= cfg_r.rst_oe_n;
    end
  end

  assign bank_a_clk_out_o = a_r;
  assign bank_b_clk_out_o = b_r;
  assign bank_c_clk_out_o = c_r;
  assign feedback_clk_out_o = fb_r;
  assign bank_a_clk_oe_o = {5{oe_r}};
  assign bank_b_clk_oe_o = {5{oe_r}};
  assign bank_c_clk_oe_o = {4{oe_r}};
  assign feedback_clk_oe_o = oe_r;

  // checks of the documented behaviour
  property p_ref_route;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!cfg_r.pll_enable && !dev_rst && vco_tick && $stable(cfg_r.ref_sel))
      |-> $past(cfg_r.ref_sel ? ref_clk_alternate_i : ref_clk_primary_i)
        && !$past(ref_d_r);
  endproperty
  a_ref_route: assert property (p_ref_route)
    else $error("bypass tick not from selected reference rise");

  property p_prescale;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (cfg_r.bank_a_sel == 1'b0) |-> (half[DIV_A] == (cfg_r.vco_prescale_select ? 5'h04 : 5'h02));
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("bank a half period ignores vco prescale");

  property p_pll_tick;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (cfg_r.pll_enable && !dev_rst) |-> vco_tick;
  endproperty
  a_pll_tick: assert property (p_pll_tick)
    else $error("vco tick missing in pll mode");

  property p_stop_low;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !cfg_r.clk_run |=> (bank_a_clk_out_o == '0) && (bank_b_clk_out_o == '0)
      && (bank_c_clk_out_o == '0);
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("bank output high during clock stop");

  property p_fb_free;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |=> feedback_clk_out_o == $past(div_q_r[DIV_FB]);
  endproperty
  a_fb_free: assert property (p_fb_free)
    else $error("feedback output not following its divider");

  property p_oe_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !cfg_r.rst_oe_n |=> !feedback_clk_oe_o && (bank_a_clk_oe_o == '0)
      && (bank_b_clk_oe_o == '0)
      && (bank_c_clk_oe_o == '0);
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven during reset/output disable");

  property p_loop_open;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    dev_rst |-> !stat.loop_closed && !vco_tick;
  endproperty
  a_loop_open: assert property (p_loop_open)
    else $error("loop closed or vco running during reset");

  property p_align;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    dev_rst |=> (div_q_r == '0) && (cnt_r[DIV_A] == '0) && (cnt_r[DIV_FB] == '0);
  endproperty
  a_align: assert property (p_align)
    else $error("dividers not cleared in reset");

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (access && paddr_i != CTRL_OFS && paddr_i != STAT_OFS) |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without slverr");

  // sampled rstn_i keeps the reset-release edge out, oe is still low there
  property p_oe_on;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (cfg_r.rst_oe_n && rstn_i) |=> feedback_clk_oe_o && (bank_a_clk_oe_o == '1)
      && (bank_b_clk_oe_o == '1) && (bank_c_clk_oe_o == '1);
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("outputs not driven with reset/output-enable high");

  // running banks follow their dividers one cycle late
  property p_stop_run;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    cfg_r.clk_run |=> (bank_a_clk_out_o == {5{$past(div_q_r[DIV_A])}})
      && (bank_b_clk_out_o == {5{$past(div_q_r[DIV_B])}})
      && (bank_c_clk_out_o == {4{$past(div_q_r[DIV_C])}});
  endproperty
  a_stop_run: assert property (p_stop_run)
    else $error("running bank output not following its divider");

  // a control write lands whole at the access edge
  property p_ctrl_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (access && pwrite_i && (paddr_i == CTRL_OFS))
      |=> (cfg_r == $past(pwdata_i[CTRL_W-1:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");

  // status read data is the state seen at the setup edge
  property p_stat_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (psel_i && !penable_i && !pwrite_i && (paddr_i == STAT_OFS))
      |=> (prdata_o == APB_DW'($past(stat)));
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read data wrong");

  // slverr only in an access phase
  property p_slverr_idle;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !access |-> !pslverr_o;
  endproperty
  a_slverr_idle: assert property (p_slverr_idle)
    else $error("slverr outside an access phase");

endmodule : pcdc_core

// ===== verification/pcdc_board_model.sv
/*
  pcdc_board_model: board side of the clock divider, two reference
  oscillators and the feedback trace.
  assumes: runs from the bench system clock; reference periods 6 and 10 cycles.
*/
module pcdc_board_model (
  // system
  input wire logic clk_sys_i,
  // clock pins
  input wire logic feedback_clk_out_i,
  output logic ref_clk_primary_o,
  output logic ref_clk_alternate_o,
  output logic feedback_clk_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int pc_r = 0;
  int ac_r = 0;
  initial ref_clk_primary_o = 1'b0;
  initial ref_clk_alternate_o = 1'b0;
  // free-running oscillators, distinct periods so a wrong pick shows
  always @(posedge clk_sys_i) begin
    pc_r <= (pc_r == 2) ? 0 : pc_r + 1;
    ac_r <= (ac_r == 4) ? 0 : ac_r + 1;
    if (pc_r == 2) ref_clk_primary_o <= ~ref_clk_primary_o;
    if (ac_r == 4) ref_clk_alternate_o <= ~ref_clk_alternate_o;
  end
  // trace from feedback output back to feedback input
  assign feedback_clk_in_o = feedback_clk_out_i;
endmodule : pcdc_board_model

// ===== verification/tb.sv
/*
  tb: self-checking bench for pcdc_core, apb master and divider timing.
  assumes: pcdc_board_model supplies references and feedback loop.
*/
module tb;
  import pcdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [9:0] ctrl; logic [3:0][4:0] h;} pcdc_row_s;
  // ctrl value, expected half periods {fb, c, b, a}
  localparam pcdc_row_s ROWS [8] = '{
    '{10'h05c, {5'h04, 5'h04, 5'h04, 5'h02}}, '{10'h1bc, {5'h08, 5'h06, 5'h02, 5'h04}},
    '{10'h21c, {5'h06, 5'h04, 5'h02, 5'h02}}, '{10'h3fc, {5'h0c, 5'h06, 5'h04, 5'h04}},
    '{10'h05e, {5'h08, 5'h08, 5'h08, 5'h04}}, '{10'h1be, {5'h10, 5'h0c, 5'h04, 5'h08}},
    '{10'h21e, {5'h0c, 5'h08, 5'h04, 5'h04}}, '{10'h3fe, {5'h18, 5'h0c, 5'h08, 5'h08}}};
  logic clk_sys_i, rstn_i, psel, penable, pwrite, pready_o, pslverr_o, e, bad;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o, q;
  logic ref_p, ref_a, feedback_clk_in, fb_out, fb_oe;
  logic [4:0] a_out, a_oe, b_out, b_oe;
  logic [3:0] c_out, c_oe, v;
  logic [14:0] oe_all;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  assign v = {fb_out, c_out[0], b_out[0], a_out[0]};
  assign oe_all = {a_oe, b_oe, c_oe, fb_oe};
  pcdc_core uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ref_clk_primary_i(ref_p),
    .ref_clk_alternate_i(ref_a), .feedback_clk_in_i(feedback_clk_in), .bank_a_clk_out_o(a_out),
    .bank_a_clk_oe_o(a_oe), .bank_b_clk_out_o(b_out), .bank_b_clk_oe_o(b_oe),
    .bank_c_clk_out_o(c_out), .bank_c_clk_oe_o(c_oe), .feedback_clk_out_o(fb_out),
    .feedback_clk_oe_o(fb_oe));
  pcdc_board_model board (.clk_sys_i(clk_sys_i), .feedback_clk_out_i(fb_out),
    .ref_clk_primary_o(ref_p), .ref_clk_alternate_o(ref_a), .feedback_clk_in_o(feedback_clk_in));
  // 125 mhz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task results;
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // hang guard, well above the expected run of under two thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // pready_o seen high ends this wait; the bench timeout catches a slave that never answers
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // cycles between two edges of one output, skipping the partial one
  task half(input int idx, output int cnt);
    logic p;
    p = v[idx];
    cnt = 0;
    while (v[idx] === p && cnt < 100) begin
      @(posedge clk_sys_i);
      cnt++;
    end
    p = v[idx];
    cnt = 0;
    while (v[idx] === p && cnt < 100) begin
      @(posedge clk_sys_i);
      cnt++;
    end
  endtask : half
  // sample outputs for a while, flag any bank activity, and feedback activity when with_fb is set
  task quiet(input logic with_fb);
    bad = 1'b0;
    repeat (24) begin
      @(posedge clk_sys_i);
      bad = bad | (|{a_out, b_out, c_out}) | (with_fb & fb_out);
    end
  endtask : quiet
  initial begin
    {rstn_i, psel, penable, pwrite, paddr, pwdata} <= '0;
    repeat (10) @(posedge clk_sys_i);
    chk(32'(oe_all), 32'h0);
    rstn_i <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h01c);
    chk(32'(oe_all), 32'h7fff);
    foreach (ROWS[i]) begin
      apb(1'b1, CTRL_OFS, 32'(ROWS[i].ctrl));
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(q, 32'(ROWS[i].ctrl));
      repeat (60) @(posedge clk_sys_i);
      for (int j = 0; j < 4; j++) begin
        half(j, n);
        chk(32'(n), 32'(ROWS[i].h[j]));
      end
    end
    // clock stop: banks held low while feedback keeps running
    apb(1'b1, CTRL_OFS, 32'h054);
    repeat (3) @(posedge clk_sys_i);
    quiet(1'b0);
    chk(32'(bad), 32'h0);
    half(3, n);
    chk(32'(n), 32'h4);
    apb(1'b1, CTRL_OFS, 32'h05c);
    half(1, n);
    half(1, n);
    chk(32'(n), 32'h4);
    // soft reset held past a reference period: outputs off, loop open
    apb(1'b1, CTRL_OFS, 32'h04c);
    repeat (3) @(posedge clk_sys_i);
    quiet(1'b1);
    chk(32'(bad), 32'h0);
    chk(32'(oe_all), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(32'({q[7], q[0]}), 32'h2);
    // release: equal dividers must run in lockstep
    apb(1'b1, CTRL_OFS, 32'h05c);
    bad = 1'b0;
    repeat (40) begin
      @(posedge clk_sys_i);
      bad = bad | (b_out[0] !== fb_out) | (c_out[0] !== fb_out) | (b_out !== {5{b_out[0]}});
      bad = bad | (a_out !== {5{a_out[0]}}) | (c_out !== {4{c_out[0]}});
    end
    chk(32'(bad), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(32'({q[7], q[0]}), 32'h1);
    // bypass: reference edges clock the dividers, selected by ref bit
    apb(1'b1, CTRL_OFS, 32'h018);
    repeat (60) @(posedge clk_sys_i);
    half(0, n);
    chk(32'(n), 32'h0c);
    apb(1'b1, CTRL_OFS, 32'h019);
    repeat (60) @(posedge clk_sys_i);
    half(0, n);
    chk(32'(n), 32'h14);
    // unmapped address refused, status not writable
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, STAT_OFS, 32'h3ff);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h019);
    chk(32'(e), 32'h0);
    // power-on reset in mid-run restores defaults
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(32'(oe_all), 32'h0);
    rstn_i <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h01c);
    results();
  end
endmodule : tb
